// >>> design/esc_crc4.sv
`timescale 1ns/1ns
// combinational check code over the zero-prefixed angle, msb first
module esc_crc4 (
  input wire logic [esc_pkg::CRC_DATA_W-1:0] data,
  output logic [esc_pkg::CRC_W-1:0] crc
);
  // one shift step per bit, leading zero first, then angle bit 22 down
  always_comb begin
    logic [esc_pkg::CRC_W-1:0] c;
    logic fb;
    c = esc_pkg::CRC_INIT;
    fb = 1'b0;
    for (int i = esc_pkg::CRC_DATA_W - 1; i >= 0; i--) begin
      fb = c[3] ^ data[i];
      c = {c[2:0], 1'b0} ^ (fb ? esc_pkg::CRC_POLY : 4'h0);
    end
    crc = c;
  end
endmodule

// >>> design/esc_host.sv
`timescale 1ns/1ns
// serial host for the rotary encoder: builds frames, checks answers, paces commands
module esc_host #(
  parameter int REG_WAIT_CYC = esc_pkg::REG_WAIT_MS * esc_pkg::CLK_KHZ,
  parameter int USER_EXIT_WAIT_CYC = esc_pkg::USER_EXIT_WAIT_MS * esc_pkg::CLK_KHZ,
  parameter int NVM_WAIT_CYC = esc_pkg::NVM_WAIT_MS * esc_pkg::CLK_KHZ
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic req,
  input wire logic [2:0] command_code,
  input wire logic [7:0] addr,
  input wire logic [15:0] wdata,
  output logic ready,
  output logic done,
  output logic [15:0] rdata,
  output logic [esc_pkg::ANGLE_BITS-1:0] angle,
  output logic crc_ok,
  output logic angle_err,
  output logic user_mode,
  output logic sclk,
  output logic cs_n,
  output logic mosi,
  input wire logic miso
);
  typedef enum logic [2:0] {ST_IDLE, ST_LEAD, ST_XFER, ST_LAG, ST_WAIT} esc_state_t;

  localparam logic [esc_pkg::CNT_W-1:0] HALF_LOAD = esc_pkg::CNT_W'(esc_pkg::SCLK_HALF_CYC - 1);
  localparam logic [esc_pkg::CNT_W-1:0] LEAD_LOAD = esc_pkg::CNT_W'(esc_pkg::LEAD_CYC - 1);
  localparam logic [esc_pkg::CNT_W-1:0] LAG_LOAD = esc_pkg::CNT_W'(esc_pkg::LAG_CYC - 1);
  localparam logic [5:0] LAST_BIT = 6'(esc_pkg::FRAME_BITS);

  esc_state_t state_reg, state_next;
  logic [esc_pkg::CNT_W-1:0] cnt_reg, cnt_next;
  logic [5:0] bit_reg, bit_next;
  logic [31:0] tx_reg, tx_next;
  logic [31:0] rx_reg, rx_next;
  logic [2:0] cmd_reg, cmd_next;
  logic [7:0] addr_reg, addr_next;
  logic [15:0] data_reg, data_next;
  logic sclk_reg, sclk_next;
  logic cs_n_reg, cs_n_next;
  logic mosi_reg, mosi_next;
  logic done_reg, done_next;
  logic [15:0] rdata_reg, rdata_next;
  logic [esc_pkg::ANGLE_BITS-1:0] angle_reg, angle_next;
  logic crc_ok_reg, crc_ok_next;
  logic err_reg, err_next;
  logic user_reg, user_next;
  logic miso_s1_reg, miso_s2_reg;
  logic [esc_pkg::CRC_W-1:0] crc_calc;
  logic mode_frame;

  // pin input crosses into clk through two flops before anything reads it
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      miso_s1_reg <= 1'b0;
      miso_s2_reg <= 1'b0;
    end else begin
      miso_s1_reg <= miso;
      miso_s2_reg <= miso_s1_reg;
    end
  end

  // check code over the leading zero and the 23 received angle bits
  esc_crc4 u_crc (
    .data({1'b0, rx_reg[esc_pkg::ANGLE_LSB +: esc_pkg::ANGLE_BITS]}),
    .crc(crc_calc)
  );

  assign mode_frame = (cmd_reg == esc_pkg::CMD_MODE_CHANGE) && (addr_reg == esc_pkg::MODE_ADDR)
                      && (data_reg == esc_pkg::MODE_KEY);

  // frame sequencer; the serial clock is this divider's output, not a second domain
  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    bit_next = bit_reg;
    tx_next = tx_reg;
    rx_next = rx_reg;
    cmd_next = cmd_reg;
    addr_next = addr_reg;
    data_next = data_reg;
    sclk_next = sclk_reg;
    cs_n_next = cs_n_reg;
    mosi_next = mosi_reg;
    done_next = 1'b0;
    rdata_next = rdata_reg;
    angle_next = angle_reg;
    crc_ok_next = crc_ok_reg;
    err_next = err_reg;
    user_next = user_reg;
    unique case (state_reg)
      ST_IDLE: begin
        sclk_next = 1'b0;
        cs_n_next = 1'b1;
        if (req) begin
          cmd_next = command_code;
          addr_next = addr;
          data_next = wdata;
          tx_next = {command_code, addr, esc_pkg::IDLE_BITS, wdata};
          rx_next = 32'h0000_0000;
          bit_next = 6'h00;
          cnt_next = LEAD_LOAD;
          cs_n_next = 1'b0;
          state_next = ST_LEAD;
        end
      end
      ST_LEAD: begin
        if (cnt_reg == '0) begin
          cnt_next = HALF_LOAD;
          state_next = ST_XFER;
        end else begin
          cnt_next = cnt_reg - 1'b1;
        end
      end
      ST_XFER: begin
        if (cnt_reg != '0) begin
          cnt_next = cnt_reg - 1'b1;
        end else if (!sclk_reg) begin
          // end of a low phase: the bit shown after the last rise has settled
          if (bit_reg != 6'h00) begin
            rx_next = {rx_reg[30:0], miso_s2_reg};
          end
          if (bit_reg == LAST_BIT) begin
            cnt_next = LAG_LOAD;
            state_next = ST_LAG;
          end else begin
            sclk_next = 1'b1;
            mosi_next = tx_reg[31];
            tx_next = {tx_reg[30:0], 1'b0};
            cnt_next = HALF_LOAD;
          end
        end else begin
          sclk_next = 1'b0;
          bit_next = bit_reg + 1'b1;
          cnt_next = HALF_LOAD;
        end
      end
      ST_LAG: begin
        if (cnt_reg != '0) begin
          cnt_next = cnt_reg - 1'b1;
        end else begin
          cs_n_next = 1'b1;
          done_next = 1'b1;
          state_next = ST_WAIT;
          cnt_next = esc_pkg::CNT_W'(REG_WAIT_CYC - 1);
          unique case (cmd_reg)
            esc_pkg::CMD_READ_REG: begin
              rdata_next = rx_reg[15:0];
            end
            esc_pkg::CMD_READ_ANGLE: begin
              angle_next = rx_reg[esc_pkg::ANGLE_LSB +: esc_pkg::ANGLE_BITS];
              crc_ok_next = (crc_calc == rx_reg[esc_pkg::CRC_LSB +: esc_pkg::CRC_W]);
              err_next = rx_reg[0];
              cnt_next = esc_pkg::CNT_W'(esc_pkg::ANGLE_WAIT_CYC - 1);
            end
            esc_pkg::CMD_NVM_PROGRAM: begin
              cnt_next = esc_pkg::CNT_W'(NVM_WAIT_CYC - 1);
            end
            esc_pkg::CMD_MODE_CHANGE: begin
              if (mode_frame) begin
                user_next = !user_reg;
                if (user_reg) begin
                  cnt_next = esc_pkg::CNT_W'(USER_EXIT_WAIT_CYC - 1);
                end
              end
            end
            default: begin
            end
          endcase
        end
      end
      ST_WAIT: begin
        // select stays high and the clock low until the device may be addressed again
        if (cnt_reg == '0) begin
          state_next = ST_IDLE;
        end else begin
          cnt_next = cnt_reg - 1'b1;
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  // registers only; mode assumed normal after reset since it cannot be read back
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_reg <= ST_IDLE;
      cnt_reg <= '0;
      bit_reg <= 6'h00;
      tx_reg <= 32'h0000_0000;
      rx_reg <= 32'h0000_0000;
      cmd_reg <= 3'h0;
      addr_reg <= 8'h00;
      data_reg <= 16'h0000;
      sclk_reg <= 1'b0;
      cs_n_reg <= 1'b1;
      mosi_reg <= 1'b0;
      done_reg <= 1'b0;
      rdata_reg <= 16'h0000;
      angle_reg <= '0;
      crc_ok_reg <= 1'b0;
      err_reg <= 1'b0;
      user_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      bit_reg <= bit_next;
      tx_reg <= tx_next;
      rx_reg <= rx_next;
      cmd_reg <= cmd_next;
      addr_reg <= addr_next;
      data_reg <= data_next;
      sclk_reg <= sclk_next;
      cs_n_reg <= cs_n_next;
      mosi_reg <= mosi_next;
      done_reg <= done_next;
      rdata_reg <= rdata_next;
      angle_reg <= angle_next;
      crc_ok_reg <= crc_ok_next;
      err_reg <= err_next;
      user_reg <= user_next;
    end
  end

  // ready is combinational; all data and pins come from flops
  assign ready = (state_reg == ST_IDLE);
  assign done = done_reg;
  assign rdata = rdata_reg;
  assign angle = angle_reg;
  assign crc_ok = crc_ok_reg;
  assign angle_err = err_reg;
  assign user_mode = user_reg;
  assign sclk = sclk_reg;
  assign cs_n = cs_n_reg;
  assign mosi = mosi_reg;
endmodule

// >>> inc/esc_pkg.sv
// What this block does
// - serial link runs mode 1: clock idles low, data sampled on second edge
// - host frames each transfer with select low and exactly 32 clock pulses
// - between transfers host holds select high and clock low
// - frame sent msb first: 3-bit command, 8-bit address, 5 idle, 16-bit data
// - command 001 programs non-volatile memory; host then waits 1000 ms
// - command 101 writes a register; host then waits 2 ms
// - command 110 reads a register's 16 bits; host then waits 2 ms
// - command 111, address 03, data EDDD enters user mode; wait 2 ms
// - same frame in user mode returns to normal mode; wait 5 ms
// - after an angle read host waits at least 2 us
package esc_pkg;
  localparam int CLK_NS = 20;
  localparam int CLK_KHZ = 50000;
  // half period of the serial clock; slow enough for a 100 ns output edge
  localparam int SCLK_HALF_NS = 100;
  localparam int SCLK_HALF_CYC = (SCLK_HALF_NS + CLK_NS - 1) / CLK_NS;
  localparam int LEAD_NS = 100;
  localparam int LEAD_CYC = (LEAD_NS + CLK_NS - 1) / CLK_NS;
  localparam int LAG_NS = 50;
  localparam int LAG_CYC = (LAG_NS + CLK_NS - 1) / CLK_NS;
  localparam int ANGLE_WAIT_US = 2;
  localparam int ANGLE_WAIT_CYC = (ANGLE_WAIT_US * CLK_KHZ + 999) / 1000;
  localparam int REG_WAIT_MS = 2;
  localparam int USER_EXIT_WAIT_MS = 5;
  localparam int NVM_WAIT_MS = 1000;
  localparam int CNT_W = 26;
  localparam int FRAME_BITS = 32;
  localparam int ANGLE_BITS = 23;
  localparam int ANGLE_LSB = 5;
  localparam int CRC_LSB = 1;
  localparam int CRC_W = 4;
  localparam int CRC_DATA_W = 24;
  localparam logic [3:0] CRC_POLY = 4'hD;
  localparam logic [3:0] CRC_INIT = 4'h3;
  localparam logic [2:0] CMD_NVM_PROGRAM = 3'h1;
  localparam logic [2:0] CMD_WRITE_REG = 3'h5;
  localparam logic [2:0] CMD_READ_REG = 3'h6;
  localparam logic [2:0] CMD_MODE_CHANGE = 3'h7;
  localparam logic [2:0] CMD_READ_ANGLE = 3'h3;
  localparam logic [7:0] MODE_ADDR = 8'h03;
  localparam logic [15:0] MODE_KEY = 16'hEDDD;
  localparam logic [4:0] IDLE_BITS = 5'h00;
endpackage

// >>> test/esc_chk.sv
`timescale 1ns/1ns
// protocol watcher beside the encoder host
module esc_chk #(
  parameter int REG_WAIT_CYC = 20,
  parameter int USER_EXIT_WAIT_CYC = 30,
  parameter int NVM_WAIT_CYC = 40
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic req,
  input wire logic [2:0] command_code,
  input wire logic [7:0] addr,
  input wire logic [15:0] wdata,
  input wire logic ready,
  input wire logic done,
  input wire logic [15:0] rdata,
  input wire logic [esc_pkg::ANGLE_BITS-1:0] angle,
  input wire logic angle_err,
  input wire logic user_mode,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic mosi,
  input wire logic miso
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  logic [27:0] t;
  logic [31:0] tx, rx;
  logic [5:0] pc;
  logic sq, hit;
  int w, wexp;
  // remember the taken request and shadow the wire at each falling edge
  always_ff @(posedge clk) begin
    sq <= sclk;
    if (req && ready) t <= {command_code, addr, wdata, user_mode};
    if (cs_n) pc <= 6'h00;
    else if (sclk && !sq) pc <= pc + 6'h01;
    if (sq && !sclk && !cs_n) {tx, rx} <= {tx[30:0], mosi, rx[30:0], miso};
    w <= done ? 0 : (ready ? w : w + 1);
  end
  assign hit = t[27:25] == 3'h7 && t[24:17] == 8'h03 && t[16:1] == 16'hEDDD;
  assign wexp = t[27:25] == 3'h3 ? esc_pkg::ANGLE_WAIT_CYC : t[27:25] == 3'h1 ?
    NVM_WAIT_CYC : (hit && t[0]) ? USER_EXIT_WAIT_CYC : REG_WAIT_CYC;
  AST_IDLE: assert property (cs_n |-> !sclk)
    else $error("clock moved while idle");
  AST_LEAD: assert property ($fell(cs_n) |-> !sclk [*5])
    else $error("clock rose too early");
  AST_PULSES: assert property ($rose(cs_n) |-> pc == 6'h20)
    else $error("pulse count wrong");
  AST_DONE: assert property (done == $rose(cs_n))
    else $error("done misplaced");
  AST_MOSI: assert property (!cs_n && $fell(sclk) |-> $stable(mosi))
    else $error("mosi moved at sampling edge");
  AST_BITS: assert property ($rose(cs_n) |-> tx == {t[27:17], 5'h00, t[16:1]})
    else $error("frame bits wrong");
  AST_REG: assert property (done && t[27:25] == 3'h6 |-> rdata == rx[15:0])
    else $error("register answer wrong");
  AST_ANG: assert property (done && t[27:25] == 3'h3 |-> {angle, angle_err} == {rx[27:5], rx[0]})
    else $error("angle answer wrong");
  AST_MODE: assert property (done |-> user_mode == (t[0] ^ hit))
    else $error("mode view wrong");
  AST_WAIT: assert property ($rose(ready) |-> w + 1 >= wexp && w <= wexp + 3)
    else $error("wait length wrong");
  cover property (done && t[27:25] == 3'h3);
  cover property ($rose(user_mode));
  cover property ($fell(user_mode));
endmodule
bind esc_host esc_chk #(.REG_WAIT_CYC(REG_WAIT_CYC), .USER_EXIT_WAIT_CYC(USER_EXIT_WAIT_CYC),
  .NVM_WAIT_CYC(NVM_WAIT_CYC)) u_chk (.clk(clk), .sys_rst(sys_rst), .req(req),
  .command_code(command_code), .addr(addr), .wdata(wdata), .ready(ready), .done(done),
  .rdata(rdata), .angle(angle), .angle_err(angle_err), .user_mode(user_mode), .sclk(sclk),
  .cs_n(cs_n), .mosi(mosi), .miso(miso));

// >>> test/esc_dev.sv
`timescale 1ns/1ns
// encoder stand-in: mode 1 slave answering angle and register reads
module esc_dev (
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic mosi,
  output logic miso,
  input wire logic [22:0] ang,
  input wire logic err,
  input wire logic bad_crc
);
  logic [31:0] rx;
  logic [27:0] ans;
  logic [5:0] n;
  logic [2:0] cmd;
  logic [7:0] adr;
  logic drv = 1'b0;
  logic bit_q = 1'b0;
  logic [15:0] regs [256];
  // check code over a zero then the angle, msb first
  function automatic logic [3:0] crc4(input logic [23:0] d);
    logic [3:0] c;
    c = 4'h3;
    for (int i = 23; i >= 0; i--) begin
      c = {c[2:0], 1'b0} ^ ((c[3] ^ d[i]) ? 4'hD : 4'h0);
    end
    return c;
  endfunction
  // answer frozen at select fall so it stays consistent; a fault flips one bit
  always @(negedge cs_n) begin
    ans <= {ang, crc4({1'b0, ang}) ^ {3'h0, bad_crc}, err};
  end
  // bits taken on the falling edge; the count clears while deselected so one process owns it
  always @(negedge sclk or posedge cs_n) begin
    if (cs_n) begin
      n <= 6'h00;
    end else begin
      n <= n + 6'h01;
      rx <= {rx[30:0], mosi};
      if (n == 6'h02) cmd <= {rx[1:0], mosi};
      if (n == 6'h0A) adr <= {rx[6:0], mosi};
      if (n == 6'h1F && cmd == 3'h5) regs[adr] <= {rx[14:0], mosi};
    end
  end
  // output moves on the rising edge; released it shows the inverse of the last bit
  always @(posedge sclk or posedge cs_n) begin
    if (cs_n) begin
      drv <= 1'b0;
    end else if (cmd == 3'h3 && n >= 6'h04) begin
      drv <= 1'b1;
      bit_q <= ans[6'h1F - n];
    end else if (cmd == 3'h6 && n >= 6'h10) begin
      drv <= 1'b1;
      bit_q <= regs[adr][6'h1F - n];
    end else begin
      drv <= 1'b0;
    end
  end
  assign miso = drv ? bit_q : ~bit_q;
endmodule

// >>> test/tb_encoder_spi_command_port.sv
`timescale 1ns/1ns
// randomised bench for the encoder host
module tb_encoder_spi_command_port;
  logic clk = 1'b0, sys_rst = 1'b1, req = 1'b0, err = 1'b0, bad = 1'b0, um = 1'b0;
  logic ready, done, crc_ok, angle_err, user_mode, sclk, cs_n, mosi, miso;
  logic [2:0] cmd = 3'h0;
  logic [7:0] adr = 8'h00, a8;
  logic [15:0] wd = 16'h0000, rdata;
  logic [22:0] ang = 23'h000000, angle;
  logic [15:0] mem [256];
  int err_count = 0, compares = 0, cyc = 0;
  always #10 clk = ~clk;
  esc_host #(.REG_WAIT_CYC(20), .USER_EXIT_WAIT_CYC(30), .NVM_WAIT_CYC(40)) u_dut (
    .clk(clk), .sys_rst(sys_rst), .req(req), .command_code(cmd), .addr(adr), .wdata(wd),
    .ready(ready), .done(done), .rdata(rdata), .angle(angle), .crc_ok(crc_ok),
    .angle_err(angle_err), .user_mode(user_mode), .sclk(sclk), .cs_n(cs_n), .mosi(mosi),
    .miso(miso));
  esc_dev u_enc (.sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso), .ang(ang), .err(err),
    .bad_crc(bad));
  task automatic chk(input string s, input logic [22:0] e, input logic [22:0] g);
    compares++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", s, e, g);
    end
  endtask
  function automatic logic mode_after(input logic [2:0] c, input logic [7:0] a,
      input logic [15:0] d, input logic m);
    return m ^ (c == 3'h7 && a == 8'h03 && d == 16'hEDDD);
  endfunction
  task automatic report_and_stop;
    $display("compares %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // request stays up through the wait, so early requests must be refused
  task automatic op(input logic [2:0] c, input logic [7:0] a, input logic [15:0] d);
    {cmd, adr, wd, req} = {c, a, d, 1'b1};
    while (ready !== 1'b1) begin
      @(posedge clk);
      #1;
    end
    @(posedge clk);
    #1;
    req = 1'b0;
    while (done !== 1'b1) begin
      @(posedge clk);
      #1;
    end
    um = mode_after(c, a, d, um);
    chk("user_mode", 23'(um), 23'(user_mode));
    if (c == 3'h6) chk("rdata", 23'(mem[a]), 23'(rdata));
    if (c == 3'h5) mem[a] = d;
    if (c == 3'h3) chk("angle", ang, angle);
    if (c == 3'h3) chk("crc_ok", 23'(!bad), 23'(crc_ok));
    if (c == 3'h3) chk("angle_err", 23'(err), 23'(angle_err));
    $display("test cmd %h addr %h finished", c, a);
  endtask
  // hang guard: about twenty frames with short waits fit well inside
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 15000) begin
      err_count++;
      report_and_stop();
    end
  end
  initial begin
    void'($urandom(32'h5E34C778));
    repeat (10) @(posedge clk);
    #1;
    sys_rst = 1'b0;
    // write then read back at both address ends and one random place
    for (int i = 0; i < 3; i++) begin
      a8 = i == 0 ? 8'h00 : i == 1 ? 8'hFF : 8'($urandom);
      op(3'h5, a8, 16'($urandom));
      op(3'h6, a8, 16'($urandom));
    end
    // angle corners, then random angles with error bit and bad check code
    for (int i = 0; i < 6; i++) begin
      ang = i == 0 ? 23'h000000 : i == 1 ? 23'h7FFFFF : 23'($urandom);
      {err, bad} = i < 2 ? 2'h0 : 2'($urandom);
      op(3'h3, 8'($urandom), 16'($urandom));
    end
    op(3'h7, 8'h03, 16'hEDDC);
    op(3'h7, 8'h03, 16'hEDDD);
    op(3'h7, 8'h04, 16'hEDDD);
    op(3'h7, 8'h03, 16'hEDDD);
    op(3'h1, 8'($urandom), 16'($urandom));
    op(3'h0, 8'h00, 16'h0000);
    op(3'h3, 8'h00, 16'h0000);
    report_and_stop();
  end
endmodule
